/* src/addr_baud_if.sv */
// Signals between the control core, the SCL divider and the address comparator
`timescale 1ns/1ps
interface addr_baud_if;
    logic [7:0] own_addr;
    logic [7:0] mask;
    logic       master_run;
    logic       ten_bit;
    logic       upper_phase;
    logic [7:0] rx_byte;
    logic       hit;
    logic       scl_low;
    modport baud (input own_addr, master_run, output scl_low);
    modport cmp  (input own_addr, mask, ten_bit, upper_phase, rx_byte, output hit);
    modport core (output own_addr, mask, master_run, ten_bit, upper_phase, rx_byte, input hit, scl_low);
endinterface

/* src/addr_baud_pkg.sv */
// Constants shared by the address match and baud divider block
// Summary of operation
// - Master SCL period is 4 x (divider + 1)
// - 10-bit upper byte top five bits fixed 11110
// - 10-bit upper byte uses register bits 2:1
// - 10-bit lower byte compares all eight bits
// - 7-bit mode uses bits 7:1, bit 0 ignored
// - Byte buffer readable, writable, never reset
// - Set mask bits 7:1 join the compare, only bits 2:1 for the 10-bit upper byte
// - Mask bit 0 counts only for the 10-bit lower byte
package addr_baud_pkg;
    localparam int          WB_AW           = 8;
    localparam int          WB_DW           = 32;
    localparam int          CNT_W           = 10;
    localparam logic [7:0]  OFS_ADDR_DIV    = 8'h00;
    localparam logic [7:0]  OFS_BYTE_BUF    = 8'h04;
    localparam logic [7:0]  OFS_MASK        = 8'h08;
    localparam logic [7:0]  OFS_CONTROL     = 8'h0C;
    localparam logic [7:0]  OFS_STATUS      = 8'h10;
    localparam logic [7:0]  RST_ADDR_DIV    = 8'h00;
    localparam logic [7:0]  RST_MASK        = 8'hFF;
    localparam logic [4:0]  RST_CONTROL     = 5'h00;
    localparam int          CTL_ENABLE_BIT  = 4;
    localparam int          ST_HIT_BIT      = 0;
    localparam int          ST_SCL_BIT      = 1;
    localparam int          ST_BADDIV_BIT   = 2;
    localparam logic [4:0]  TEN_BIT_HEADER  = 5'h1E;
    localparam logic [7:0]  DIV_MIN_LEGAL   = 8'h03;
    localparam logic [3:0]  MODE_SLAVE7     = 4'h6;
    localparam logic [3:0]  MODE_SLAVE10    = 4'h7;
    localparam logic [3:0]  MODE_MASTER     = 4'h8;
    localparam logic [3:0]  MODE_SLAVE7_SP  = 4'hE;
    localparam logic [3:0]  MODE_SLAVE10_SP = 4'hF;
endpackage

/* src/addr_baud_top.sv */
// Register file, address match and SCL divider of the two-wire port
`timescale 1ns/1ps
module addr_baud_top
    import addr_baud_pkg::*;
(
    // Clock and reset
    input  wire logic                                  mclk,
    input  wire logic                                  sys_rst,
    // Wishbone slave
    input  wire logic                                  wb_cyc_i,
    input  wire logic                                  wb_stb_i,
    input  wire logic                                  wb_we_i,
    input  wire logic [addr_baud_pkg::WB_AW-1:0]       wb_adr_i,
    input  wire logic [addr_baud_pkg::WB_DW/8-1:0]     wb_sel_i,
    input  wire logic [addr_baud_pkg::WB_DW-1:0]       wb_dat_i,
    output logic      [addr_baud_pkg::WB_DW-1:0]       wb_dat_o,
    output logic                                       wb_ack_o,
    // Received address bytes from the shift logic
    input  wire logic [7:0]                            rx_byte,
    input  wire logic                                  rx_valid,
    input  wire logic                                  rx_upper,
    // Match result
    output logic                                       addr_match,
    // SCL open-drain pin
    output logic                                       scl_o,
    output logic                                       scl_oe
);
    import addr_baud_pkg::*;

    addr_baud_if link ();

    logic [7:0]       addr_div_reg;
    logic [7:0]       addr_div_next;
    logic [7:0]       mask_reg;
    logic [7:0]       mask_next;
    logic [4:0]       control_reg;
    logic [4:0]       control_next;
    logic             hit_seen_reg;
    logic             hit_seen_next;
    logic [7:0]       byte_buf_reg;
    logic [7:0]       byte_buf_next;
    logic [WB_DW-1:0] dat_reg;
    logic [WB_DW-1:0] dat_next;
    logic             ack_reg;
    logic             ack_next;
    logic             match_reg;
    logic             match_next;
    logic             scl_oe_reg;
    logic             scl_oe_next;
    logic             wr_en;
    logic             rd_en;
    logic [3:0]       mode;
    logic             enabled;
    logic             is_master;
    logic             is_ten;
    logic             is_slave;
    logic             bad_div;

    scl_divider u_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .bus     (link.baud)
    );

    addr_comparator u_cmp (
        .bus (link.cmp)
    );

    assign mode      = control_reg[3:0];
    assign enabled   = control_reg[CTL_ENABLE_BIT];
    assign is_master = enabled && (mode == MODE_MASTER);
    assign is_ten    = (mode == MODE_SLAVE10) || (mode == MODE_SLAVE10_SP);
    assign is_slave  = enabled && (is_ten || mode == MODE_SLAVE7 || mode == MODE_SLAVE7_SP);
    // Small dividers are not guarded in hardware; status only reports them
    assign bad_div   = addr_div_reg < DIV_MIN_LEGAL;

    assign link.own_addr    = addr_div_reg;
    assign link.mask        = mask_reg;
    assign link.master_run  = is_master;
    assign link.ten_bit     = is_ten;
    assign link.upper_phase = rx_upper;
    assign link.rx_byte     = rx_byte;

    // Access is taken on the first cycle of a request, answered one cycle later
    assign wr_en = wb_cyc_i && wb_stb_i && !ack_reg && wb_we_i && wb_sel_i[0];
    assign rd_en = wb_cyc_i && wb_stb_i && !ack_reg && !wb_we_i;

    // Register writes and hardware updates
    always_comb
    begin
        addr_div_next = addr_div_reg;
        mask_next     = mask_reg;
        control_next  = control_reg;
        hit_seen_next = hit_seen_reg;
        byte_buf_next = byte_buf_reg;
        if (wr_en)
        begin
            unique case (wb_adr_i)
                OFS_ADDR_DIV: addr_div_next = wb_dat_i[7:0];
                OFS_BYTE_BUF: byte_buf_next = wb_dat_i[7:0];
                OFS_MASK:     mask_next     = wb_dat_i[7:0];
                OFS_CONTROL:  control_next  = wb_dat_i[4:0];
                OFS_STATUS:   hit_seen_next = hit_seen_reg && !wb_dat_i[ST_HIT_BIT];
                default:      control_next  = control_reg;
            endcase
        end
        // A received byte wins over a software write in the same cycle
        if (is_slave && rx_valid)
            byte_buf_next = rx_byte;
        // Set wins over a write-one clear
        if (is_slave && rx_valid && link.hit)
            hit_seen_next = 1'b1;
    end

    // Bus answer, match pulse and pin drive
    always_comb
    begin
        ack_next    = wb_cyc_i && wb_stb_i && !ack_reg;
        dat_next    = '0;
        match_next  = is_slave && rx_valid && link.hit;
        scl_oe_next = link.scl_low;
        if (rd_en)
        begin
            unique case (wb_adr_i)
                OFS_ADDR_DIV: dat_next[7:0] = addr_div_reg;
                OFS_BYTE_BUF: dat_next[7:0] = byte_buf_reg;
                OFS_MASK:     dat_next[7:0] = mask_reg;
                OFS_CONTROL:  dat_next[4:0] = control_reg;
                OFS_STATUS:   dat_next[2:0] = {bad_div, !scl_oe_reg, hit_seen_reg};
                default:      dat_next      = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_div_reg <= RST_ADDR_DIV;
            mask_reg     <= RST_MASK;
            control_reg  <= RST_CONTROL;
            hit_seen_reg <= 1'b0;
            dat_reg      <= '0;
            ack_reg      <= 1'b0;
            match_reg    <= 1'b0;
            scl_oe_reg   <= 1'b0;
        end
        else
        begin
            addr_div_reg <= addr_div_next;
            mask_reg     <= mask_next;
            control_reg  <= control_next;
            hit_seen_reg <= hit_seen_next;
            dat_reg      <= dat_next;
            ack_reg      <= ack_next;
            match_reg    <= match_next;
            scl_oe_reg   <= scl_oe_next;
        end
    end

    // Buffer keeps its content through every reset, so it has none
    always_ff @(posedge mclk)
    begin
        byte_buf_reg <= byte_buf_next;
    end

    assign wb_dat_o   = dat_reg;
    assign wb_ack_o   = ack_reg;
    assign addr_match = match_reg;
    assign scl_o      = 1'b0;
    assign scl_oe     = scl_oe_reg;

    a_upper_header_fixed: assert property (@(posedge mclk) disable iff (sys_rst)
        (is_slave && is_ten && rx_valid && rx_upper && rx_byte[7:3] != TEN_BIT_HEADER) |=> !addr_match)
        else $error("10-bit header mismatch gave a match");
    a_upper_two_bits: assert property (@(posedge mclk) disable iff (sys_rst)
        (is_slave && is_ten && rx_valid && rx_upper && rx_byte[7:3] == TEN_BIT_HEADER
         && rx_byte[2:1] == addr_div_reg[2:1]) |=> addr_match)
        else $error("10-bit upper byte missed a match");
    a_lower_full_byte: assert property (@(posedge mclk) disable iff (sys_rst)
        (is_slave && is_ten && rx_valid && !rx_upper) |=> (addr_match == $past(
         ((rx_byte ^ addr_div_reg) & mask_reg) == 8'h00)))
        else $error("10-bit lower byte compare wrong");
    a_seven_bit_addr: assert property (@(posedge mclk) disable iff (sys_rst)
        (is_slave && !is_ten && rx_valid && rx_byte[7:1] == addr_div_reg[7:1]) |=> addr_match)
        else $error("7-bit address missed a match");
    // Buffer is unknown until first loaded, so compare case-equal to avoid a false alarm
    a_buffer_holds: assert property (@(posedge mclk) disable iff (sys_rst)
        (!(is_slave && rx_valid) && !(wr_en && wb_adr_i == OFS_BYTE_BUF))
        |=> (byte_buf_reg === $past(byte_buf_reg)))
        else $error("Byte buffer changed without cause");
    a_buffer_loads: assert property (@(posedge mclk) disable iff (sys_rst)
        (is_slave && rx_valid) |=> (byte_buf_reg == $past(rx_byte)))
        else $error("Byte buffer missed a received byte");
    a_mask_excludes: assert property (@(posedge mclk) disable iff (sys_rst)
        (is_slave && !is_ten && rx_valid && ((rx_byte ^ addr_div_reg) & mask_reg & 8'hFE) != 8'h00)
        |=> !addr_match)
        else $error("Masked-in bit difference still matched");
    a_mask0_seven: assert property (@(posedge mclk) disable iff (sys_rst)
        (is_slave && !is_ten && rx_valid && ((rx_byte ^ addr_div_reg) & mask_reg & 8'hFE) == 8'h00)
        |=> addr_match)
        else $error("Bit 0 affected a 7-bit match");
    a_ack_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus answer not a single cycle");
endmodule

/* src/addr_comparator.sv */
// Own address comparator for 7-bit and 10-bit target modes
`timescale 1ns/1ps
module addr_comparator
    import addr_baud_pkg::*;
(
    // Core side
    addr_baud_if.cmp bus
);
    logic [7:0] diff;

    // Only mask bits that are set take part in the compare
    assign diff = (bus.rx_byte ^ bus.own_addr) & bus.mask;

    always_comb
    begin
        if (!bus.ten_bit)
            bus.hit = (diff[7:1] == 7'h00);
        else if (bus.upper_phase)
            // Header is fixed by the bus; register bits 7:3 and 0 play no part
            bus.hit = (bus.rx_byte[7:3] == TEN_BIT_HEADER) && (diff[2:1] == 2'h0);
        else
            bus.hit = (diff == 8'h00);
    end
endmodule

/* src/scl_divider.sv */
// SCL generator for bus master operation
`timescale 1ns/1ps
module scl_divider
    import addr_baud_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Core side
    addr_baud_if.baud bus
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             low_reg;
    logic             low_next;
    logic [CNT_W-1:0] limit;

    // Half period is 2 x (divider + 1) cycles, so a full period is 4 x (divider + 1)
    assign limit = CNT_W'({bus.own_addr, 1'b1});

    always_comb
    begin
        cnt_next = cnt_reg;
        low_next = low_reg;
        if (!bus.master_run)
        begin
            cnt_next = '0;
            low_next = 1'b0;
        end
        else if (cnt_reg >= limit)
        begin
            cnt_next = '0;
            low_next = !low_reg;
        end
        else
        begin
            cnt_next = cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= '0;
            low_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            low_reg <= low_next;
        end
    end

    assign bus.scl_low = low_reg;

    a_scl_toggle_at_limit: assert property (@(posedge mclk) disable iff (sys_rst)
        (bus.master_run && cnt_reg == limit && $stable(bus.own_addr)) |=> (low_reg != $past(low_reg)))
        else $error("SCL did not toggle at divider limit");
    a_scl_hold_below: assert property (@(posedge mclk) disable iff (sys_rst)
        (bus.master_run && cnt_reg < limit) |=> $stable(low_reg))
        else $error("SCL toggled before divider limit");
endmodule

/* testbench/bus_peer_model.sv */
// Far-side bus peer: address byte source and SCL pull-up
`timescale 1ns/1ps
module bus_peer_model (
    // Clock
    input  wire logic       mclk,
    // SCL pin of the port
    input  wire logic       scl_o,
    input  wire logic       scl_oe,
    output logic            scl_line,
    // Address bytes toward the port
    output logic [7:0]      rx_byte,
    output logic            rx_valid,
    output logic            rx_upper
);
    // Pull-up: a released SCL reads high
    assign scl_line = scl_oe ? scl_o : 1'b1;
    initial
    begin
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
        rx_upper = 1'b0;
    end
    // Inverted leftovers so a stale byte never passes for a fresh one
    task automatic send(input logic [7:0] b, input logic up);
        @(posedge mclk);
        rx_byte  <= b;
        rx_valid <= 1'b1;
        rx_upper <= up;
        @(posedge mclk);
        rx_byte  <= ~b;
        rx_valid <= 1'b0;
        rx_upper <= ~up;
    endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the address match and baud divider block
`timescale 1ns/1ps
module testbench;
    import addr_baud_pkg::*;
    logic                mclk;
    logic                sys_rst;
    logic                wb_cyc_i;
    logic                wb_stb_i;
    logic                wb_we_i;
    logic [WB_AW-1:0]    wb_adr_i;
    logic [WB_DW/8-1:0]  wb_sel_i;
    logic [WB_DW-1:0]    wb_dat_i;
    logic [WB_DW-1:0]    wb_dat_o;
    logic                wb_ack_o;
    logic [7:0]          rx_byte;
    logic                rx_valid;
    logic                rx_upper;
    logic                addr_match;
    logic                scl_o;
    logic                scl_oe;
    logic                scl_line;
    int                  failures;
    int                  n_compared;

    addr_baud_top uut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_upper(rx_upper), .addr_match(addr_match), .scl_o(scl_o), .scl_oe(scl_oe));
    bus_peer_model peer (.mclk(mclk), .scl_o(scl_o), .scl_oe(scl_oe), .scl_line(scl_line),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_upper(rx_upper));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout;
        failures++;
        $display("[FAIL] %0t wait ran out", $time);
        report_and_stop;
    endtask

    // Classic cycle: held until ack is sampled, then an idle cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [31:0] rd);
        int n;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, dat};
        for (n = 0; n < 20; n++)
        begin
            @(posedge mclk);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (n == 20)
            timeout;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb(1'b0, adr, 8'h00, d);
        check(d, exp);
    endtask

    task automatic hit_chk(input logic [7:0] b, input logic up, input logic exp);
        peer.send(b, up);
        #1;
        check({31'h0, addr_match}, {31'h0, exp});
    endtask

    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
    endtask

    task automatic t_regs;
        rd_chk(OFS_ADDR_DIV, 32'h00);
        rd_chk(OFS_MASK, 32'hFF);
        rd_chk(OFS_CONTROL, 32'h00);
        wr(8'h14, 8'hFF);
        rd_chk(8'h14, 32'h00);
        wr(OFS_BYTE_BUF, 8'h3C);
        rd_chk(OFS_BYTE_BUF, 32'h3C);
        do_reset;
        rd_chk(OFS_BYTE_BUF, 32'h3C);
        $display("registers done");
    endtask

    task automatic t_seven(input logic [3:0] mode);
        wr(OFS_ADDR_DIV, 8'hA5);
        wr(OFS_MASK, 8'hFF);
        wr(OFS_CONTROL, {4'h1, mode});
        hit_chk(8'hA4, 1'b1, 1'b1);
        hit_chk(8'hA6, 1'b0, 1'b0);
        rd_chk(OFS_BYTE_BUF, 32'hA6);
        rd_chk(OFS_STATUS, 32'h03);
        wr(OFS_STATUS, 8'h01);
        rd_chk(OFS_STATUS, 32'h02);
        wr(OFS_MASK, 8'hFD);
        hit_chk(8'hA6, 1'b0, 1'b1);
        hit_chk(8'hA2, 1'b0, 1'b0);
        $display("seven-bit mode %h done", mode);
    endtask

    task automatic t_ten(input logic [3:0] mode);
        wr(OFS_ADDR_DIV, 8'h5B);
        wr(OFS_MASK, 8'hFF);
        wr(OFS_CONTROL, {4'h1, mode});
        hit_chk(8'hF2, 1'b1, 1'b1);
        hit_chk(8'hF3, 1'b1, 1'b1);
        hit_chk(8'hE2, 1'b1, 1'b0);
        hit_chk(8'hF4, 1'b1, 1'b0);
        hit_chk(8'h5B, 1'b0, 1'b1);
        hit_chk(8'hDB, 1'b0, 1'b0);
        hit_chk(8'h5A, 1'b0, 1'b0);
        wr(OFS_MASK, 8'hFE);
        hit_chk(8'h5A, 1'b0, 1'b1);
        $display("ten-bit mode %h done", mode);
    endtask

    task automatic t_scl;
        int d;
        int n;
        int k;
        logic last;
        for (d = 3; d <= 7; d += 4)
        begin
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_ADDR_DIV, d[7:0]);
            wr(OFS_CONTROL, {4'h1, MODE_MASTER});
            for (k = 0; k < 2; k++)
            begin
                last = scl_line;
                for (n = 1; n < 200; n++)
                begin
                    @(posedge mclk);
                    if (last === 1'b1 && scl_line === 1'b0)
                        break;
                    last = scl_line;
                end
                if (n == 200)
                    timeout;
            end
            check(32'(n), 32'(4 * (d + 1)));
            hit_chk(d[7:0], 1'b0, 1'b0);
        end
        wr(OFS_CONTROL, 8'h00);
        $display("scl done");
    endtask

    initial
    begin
        failures = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = '0;
        wb_dat_i = '0;
        do_reset;
        t_regs;
        t_seven(MODE_SLAVE7);
        t_seven(MODE_SLAVE7_SP);
        t_ten(MODE_SLAVE10);
        t_ten(MODE_SLAVE10_SP);
        t_scl;
        report_and_stop;
    end
endmodule
